// ===== common/ncp_pkg.sv
// Constants and types shared by the numeric coprocessor interface.
package ncp_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int EXT_W  = 80;
  localparam int WORK_W = 84;
  localparam int NREG   = 8;
  // ----------------------------------------------------------------
  // Host port map and bus status codes {status_one, status_zero}
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_CMD   = 8'hf8;
  localparam logic [7:0] PORT_DATA  = 8'hfa;
  localparam logic [7:0] PORT_CTRL  = 8'hfc;
  localparam logic [4:0] PORT_RANGE = 5'h1f;
  localparam logic [1:0] BUS_RD     = 2'b10;
  localparam logic [1:0] BUS_WR     = 2'b01;
  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_FMT_LSB = 4;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_POP_BIT = 11;
  // ----------------------------------------------------------------
  // Status word fields, exception flags and reset values
  // ----------------------------------------------------------------
  localparam int SW_BUSY_BIT = 15;
  localparam int SW_TOP_LSB  = 12;
  localparam int SW_SUM_BIT  = 7;
  localparam int FLG_INVALID = 0;
  localparam logic [15:0] CW_RESET  = 16'h003f;
  localparam logic [7:0]  TAG_RESET = 8'hff;
  localparam logic [3:0]  EXEC_CYCLES = 4'h4;
  // ----------------------------------------------------------------
  // Number formats
  // ----------------------------------------------------------------
  localparam logic [14:0] EXP_BIAS = 15'h3fff;
  localparam logic [14:0] EXP_MAX  = 15'h7fff;
  localparam logic [14:0] R32_BIAS = 15'h007f;
  localparam logic [14:0] R64_BIAS = 15'h03ff;
  localparam logic [79:0] ONE_EXT  = 80'h3fff_8000_0000_0000_0000;
  localparam logic [63:0] INT_INDEF = 64'h8000_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_LOAD, OP_STORE, OP_XCHG, OP_CHS, OP_ABS, OP_LDZ, OP_LD1, OP_CLEX, OP_INIT
  } ncp_op_t;

  typedef enum logic [2:0] {
    FMT_I16, FMT_I32, FMT_I64, FMT_BCD, FMT_R32, FMT_R64, FMT_R80
  } ncp_fmt_t;

  // Number of 16-bit memory words an operand occupies.
  function automatic logic [2:0] ncp_words(input ncp_fmt_t f);
    case (f)
      FMT_I16: ncp_words = 3'd1;
      FMT_I32, FMT_R32: ncp_words = 3'd2;
      FMT_I64, FMT_R64: ncp_words = 3'd4;
      default: ncp_words = 3'd5;
    endcase
  endfunction
endpackage

// ===== core/ncp_fmt_conv.sv
// Conversion between memory operand formats and the extended format.
`timescale 1ns/10ps
module ncp_fmt_conv (
  input  wire ncp_pkg::ncp_fmt_t fmt,
  input  wire logic [79:0]       mem_in,
  input  wire logic [79:0]       ext_in,
  output logic [79:0]            ld_ext,
  output logic [79:0]            st_mem
);
  import ncp_pkg::*;

  function automatic logic [79:0] norm(input logic s, input logic [63:0] mag);
    logic [6:0] lz;
    lz = 7'd0;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) lz = 7'(63 - i);
    end
    if (mag == 64'h0) norm = 80'h0;
    else norm = {s, 15'(EXP_BIAS + 15'd63 - {8'h0, lz}), 64'(mag << lz)};
  endfunction

  // ----------------------------------------------------------------
  // Load direction
  // ----------------------------------------------------------------
  logic [63:0] sx;
  logic [63:0] bcdbin;
  always_comb begin
    sx = 64'h0;
    bcdbin = 64'h0;
    ld_ext = 80'h0;
    for (int i = 17; i >= 0; i--) begin
      bcdbin = 64'(bcdbin * 64'd10) + {60'h0, mem_in[4*i+:4]};
    end
    case (fmt)
      FMT_I16: sx = {{48{mem_in[15]}}, mem_in[15:0]};
      FMT_I32: sx = {{32{mem_in[31]}}, mem_in[31:0]};
      default: sx = mem_in[63:0];
    endcase
    case (fmt)
      FMT_I16, FMT_I32, FMT_I64: ld_ext = norm(sx[63], sx[63] ? 64'(-sx) : sx);
      FMT_BCD: ld_ext = norm(mem_in[79], bcdbin);
      FMT_R32: begin
        if (mem_in[30:23] == 8'h0) ld_ext = {mem_in[31], 79'h0};
        else if (mem_in[30:23] == 8'hff) ld_ext = {mem_in[31], EXP_MAX, 1'b1, mem_in[22:0], 40'h0};
        else ld_ext = {mem_in[31], 15'(EXP_BIAS - R32_BIAS + {7'h0, mem_in[30:23]}),
                       1'b1, mem_in[22:0], 40'h0};
      end
      FMT_R64: begin
        if (mem_in[62:52] == 11'h0) ld_ext = {mem_in[63], 79'h0};
        else if (mem_in[62:52] == 11'h7ff) ld_ext = {mem_in[63], EXP_MAX, 1'b1, mem_in[51:0], 11'h0};
        else ld_ext = {mem_in[63], 15'(EXP_BIAS - R64_BIAS + {4'h0, mem_in[62:52]}),
                       1'b1, mem_in[51:0], 11'h0};
      end
      default: ld_ext = mem_in;
    endcase
  end

  // ----------------------------------------------------------------
  // Store direction; integers truncate toward zero, reals truncate.
  // ----------------------------------------------------------------
  logic        s;
  logic [14:0] ex;
  logic [14:0] sh;
  logic [14:0] lim;
  logic [63:0] mag;
  logic [63:0] ival;
  logic [71:0] bcd;
  always_comb begin
    s = ext_in[79];
    ex = ext_in[78:64];
    sh = 15'(ex - EXP_BIAS);
    mag = 64'h0;
    bcd = 72'h0;
    st_mem = 80'h0;
    case (fmt)
      FMT_I16: lim = 15'd15;
      FMT_I32: lim = 15'd31;
      FMT_BCD: lim = 15'd60;
      default: lim = 15'd63;
    endcase
    if (ex >= EXP_BIAS && sh < lim) mag = ext_in[63:0] >> (15'd63 - sh);
    ival = s ? 64'(-mag) : mag;
    if (ex >= EXP_BIAS && sh >= lim) ival = INT_INDEF;
    for (int b = 63; b >= 0; b--) begin
      for (int d = 0; d < 18; d++) begin
        if (bcd[4*d+:4] >= 4'd5) bcd[4*d+:4] = 4'(bcd[4*d+:4] + 4'd3);
      end
      bcd = {bcd[70:0], mag[b]};
    end
    case (fmt)
      FMT_I16: st_mem = {64'h0, ival[63], ival[14:0]};
      FMT_I32: st_mem = {48'h0, ival[63], ival[30:0]};
      FMT_I64: st_mem = {16'h0, ival};
      FMT_BCD: st_mem = {s, 7'h0, bcd};
      FMT_R32: begin
        if (ex == EXP_MAX || ex > EXP_BIAS + R32_BIAS) st_mem = {48'h0, s, 8'hff, 23'h0};
        else if (ex > EXP_BIAS - R32_BIAS)
          st_mem = {48'h0, s, 8'(ex - EXP_BIAS + R32_BIAS), ext_in[62:40]};
        else st_mem = {48'h0, s, 31'h0};
      end
      FMT_R64: begin
        if (ex == EXP_MAX || ex > EXP_BIAS + R64_BIAS) st_mem = {16'h0, s, 11'h7ff, 52'h0};
        else if (ex > EXP_BIAS - R64_BIAS)
          st_mem = {16'h0, s, 11'(ex - EXP_BIAS + R64_BIAS), ext_in[62:11]};
        else st_mem = {16'h0, s, 63'h0};
      end
      default: st_mem = ext_in;
    endcase
  end
endmodule

// ===== core/ncp_coproc.sv
// Host-facing interface unit and execution unit of the numeric coprocessor.
`timescale 1ns/10ps
module ncp_coproc (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       host_bus_status_one,
  input  wire logic                       host_bus_status_zero,
  input  wire logic                       code_or_int_ack_status,
  input  wire logic                       host_ready_n,
  input  wire logic                       hold_acknowledge,
  input  wire logic [ncp_pkg::ADDR_W-1:0] host_io_addr,
  input  wire logic [ncp_pkg::DATA_W-1:0] host_data_in,
  output logic      [ncp_pkg::DATA_W-1:0] host_data_out,
  output logic                            host_data_oe,
  output logic                            operand_xfer_request,
  input  wire logic                       operand_xfer_ack_n,
  output logic                            busy_n,
  output logic                            error_n
);
  import ncp_pkg::*;

  typedef enum logic [1:0] {EX_IDLE, EX_FETCH, EX_RUN, EX_STORE} ncp_state_t;

  // ----------------------------------------------------------------
  // Host pin registration
  // ----------------------------------------------------------------
  logic              stat1_reg, stat0_reg, coda_reg, rdy_n_reg, hold_reg, ack_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] din_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {stat1_reg, stat0_reg, coda_reg, rdy_n_reg, hold_reg, ack_n_reg} <= 6'h3f;
      addr_reg <= 8'h0;
      din_reg  <= 16'h0;
    end else begin
      {stat1_reg, stat0_reg} <= {host_bus_status_one, host_bus_status_zero};
      coda_reg  <= code_or_int_ack_status;
      rdy_n_reg <= host_ready_n;
      hold_reg  <= hold_acknowledge;
      ack_n_reg <= operand_xfer_ack_n;
      addr_reg  <= host_io_addr;
      din_reg   <= host_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle decode
  // ----------------------------------------------------------------
  wire data_cyc = !hold_reg && !coda_reg && addr_reg[7:3] == PORT_RANGE;
  wire rd_cyc   = data_cyc && {stat1_reg, stat0_reg} == BUS_RD;
  wire wr_cyc   = data_cyc && {stat1_reg, stat0_reg} == BUS_WR;
  wire done     = !rdy_n_reg;
  wire wr_cmd   = wr_cyc && done && addr_reg == PORT_CMD;
  wire wr_ctrl  = wr_cyc && done && addr_reg == PORT_CTRL;
  wire wr_data_done = wr_cyc && done && addr_reg == PORT_DATA && !ack_n_reg;
  wire rd_data_done = rd_cyc && done && addr_reg == PORT_DATA && !ack_n_reg;

  wire ncp_op_t  op_in  = ncp_op_t'(din_reg[CMD_OP_LSB+:4]);
  wire ncp_fmt_t fmt_in = ncp_fmt_t'(din_reg[CMD_FMT_LSB+:3]);
  wire           is_ctl = op_in == OP_CLEX || op_in == OP_INIT;

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  ncp_state_t  state_reg, state_next;
  ncp_op_t     op_reg;
  ncp_fmt_t    fmt_reg;
  logic [2:0]  idx_reg;
  logic        pop_reg;
  logic [2:0]  cnt_reg, cnt_next;
  logic [3:0]  run_reg, run_next;
  logic [79:0] opbuf_reg, opbuf_next;
  logic [2:0]  top_reg, top_next;
  logic [7:0]  tag_reg, tag_next;
  logic [5:0]  flags_reg, flags_next;
  logic [15:0] cw_reg, cw_next;
  logic [79:0] stk [NREG];
  logic        wa_en, wb_en;
  logic [2:0]  wa_idx, wb_idx;
  logic [79:0] wa_val, wb_val;
  logic [79:0] ld_ext, st_mem;

  wire err_sum      = |(flags_reg & ~cw_reg[5:0]);
  wire err_sum_next = |(flags_next & ~cw_next[5:0]);
  wire cmd_accept   = wr_cmd && !is_ctl && state_reg == EX_IDLE && !err_sum;
  wire [2:0] top_dn  = top_reg - 3'd1;
  wire [2:0] idx_abs = top_reg + idx_reg;
  wire [2:0] words   = ncp_words(fmt_reg);
  wire [79:0] top_val = stk[top_reg];

  // Unpacked working value: sign, exponent, 64-bit fraction plus guard bits.
  wire [WORK_W-1:0] work     = {top_val[79], top_val[78:64], top_val[63:0], 4'h0};
  wire [WORK_W-1:0] work_chs = {~work[83], work[82:0]};
  wire [WORK_W-1:0] work_abs = {1'b0, work[82:0]};

  ncp_fmt_conv u_conv (
    .fmt    (fmt_reg),
    .mem_in (opbuf_reg),
    .ext_in (top_val),
    .ld_ext (ld_ext),
    .st_mem (st_mem)
  );

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    run_next   = run_reg;
    opbuf_next = opbuf_reg;
    top_next   = top_reg;
    tag_next   = tag_reg;
    flags_next = flags_reg;
    cw_next    = cw_reg;
    wa_en = 1'b0;
    wb_en = 1'b0;
    wa_idx = top_reg;
    wb_idx = idx_abs;
    wa_val = ld_ext;
    wb_val = top_val;
    if (wr_ctrl) cw_next = din_reg;
    if (wr_cmd && op_in == OP_CLEX) flags_next = 6'h0;
    case (state_reg)
      EX_IDLE: begin
        if (cmd_accept) begin
          cnt_next = 3'd0;
          run_next = EXEC_CYCLES;
          state_next = (op_in == OP_LOAD) ? EX_FETCH : EX_RUN;
        end
      end
      EX_FETCH: begin
        if (wr_data_done) begin
          opbuf_next[{cnt_reg, 4'h0}+:16] = din_reg;
          cnt_next = cnt_reg + 3'd1;
          if (cnt_reg == words - 3'd1) state_next = EX_RUN;
        end
      end
      EX_RUN: begin
        if (run_reg != 4'h0) run_next = run_reg - 4'h1;
        else begin
          state_next = EX_IDLE;
          case (op_reg)
            OP_LOAD, OP_LDZ, OP_LD1: begin
              if (!tag_reg[top_dn]) flags_next[FLG_INVALID] = 1'b1;
              else begin
                top_next = top_dn;
                tag_next[top_dn] = 1'b0;
                wa_en = 1'b1;
                wa_idx = top_dn;
                wa_val = (op_reg == OP_LOAD) ? ld_ext : (op_reg == OP_LD1) ? ONE_EXT : 80'h0;
              end
            end
            OP_STORE: begin
              if (tag_reg[top_reg]) flags_next[FLG_INVALID] = 1'b1;
              else begin
                opbuf_next = st_mem;
                cnt_next = 3'd0;
                state_next = EX_STORE;
                if (pop_reg) begin
                  tag_next[top_reg] = 1'b1;
                  top_next = top_reg + 3'd1;
                end
              end
            end
            OP_XCHG: begin
              if (tag_reg[top_reg] || tag_reg[idx_abs]) flags_next[FLG_INVALID] = 1'b1;
              else begin
                wa_en = 1'b1;
                wa_val = stk[idx_abs];
                wb_en = 1'b1;
              end
            end
            OP_CHS, OP_ABS: begin
              if (tag_reg[top_reg]) flags_next[FLG_INVALID] = 1'b1;
              else begin
                wa_en = 1'b1;
                wa_val = (op_reg == OP_CHS) ? work_chs[83:4] : work_abs[83:4];
              end
            end
            default: state_next = EX_IDLE;
          endcase
        end
      end
      EX_STORE: begin
        if (rd_data_done) begin
          cnt_next = cnt_reg + 3'd1;
          if (cnt_reg == words - 3'd1) state_next = EX_IDLE;
        end
      end
      default: state_next = EX_IDLE;
    endcase
    if (wr_cmd && op_in == OP_INIT) begin
      state_next = EX_IDLE;
      top_next   = 3'd0;
      tag_next   = TAG_RESET;
      flags_next = 6'h0;
      cw_next    = CW_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Host-visible words and output selection
  // ----------------------------------------------------------------
  wire [15:0] status_word = (16'(state_reg != EX_IDLE || err_sum) << SW_BUSY_BIT)
                          | (16'(top_reg) << SW_TOP_LSB)
                          | (16'(err_sum) << SW_SUM_BIT)
                          | {10'h0, flags_reg};
  wire [15:0] rd_word = (addr_reg == PORT_CMD)  ? status_word :
                        (addr_reg == PORT_CTRL) ? cw_reg :
                        (addr_reg == PORT_DATA) ? opbuf_reg[{cnt_reg, 4'h0}+:16] : 16'h0;
  wire rd_ours = rd_cyc && (addr_reg == PORT_CMD || addr_reg == PORT_CTRL
                            || addr_reg == PORT_DATA);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= EX_IDLE;
      op_reg <= OP_LOAD;
      fmt_reg <= FMT_I16;
      idx_reg <= 3'd0;
      pop_reg <= 1'b0;
      cnt_reg <= 3'd0;
      run_reg <= 4'h0;
      opbuf_reg <= 80'h0;
      top_reg <= 3'd0;
      tag_reg <= TAG_RESET;
      flags_reg <= 6'h0;
      cw_reg <= CW_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      opbuf_reg <= opbuf_next;
      top_reg <= top_next;
      tag_reg <= tag_next;
      flags_reg <= flags_next;
      cw_reg <= cw_next;
      if (cmd_accept) begin
        op_reg <= op_in;
        fmt_reg <= fmt_in;
        idx_reg <= din_reg[CMD_IDX_LSB+:3];
        pop_reg <= din_reg[CMD_POP_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wa_en) stk[wa_idx] <= wa_val;
    if (wb_en) stk[wb_idx] <= wb_val;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_n <= 1'b1;
      error_n <= 1'b1;
      operand_xfer_request <= 1'b0;
      host_data_out <= 16'h0;
      host_data_oe <= 1'b0;
    end else begin
      busy_n <= !(state_next != EX_IDLE || err_sum_next);
      error_n <= !err_sum_next;
      operand_xfer_request <= state_next == EX_FETCH || state_next == EX_STORE;
      host_data_out <= rd_word;
      host_data_oe <= rd_ours;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_error_follows_sum;
    error_n == !err_sum;
  endproperty
  a_error_follows_sum: assert property (p_error_follows_sum) else $error("error pin disagrees with summary");

  property p_busy_when_running;
    (state_reg != EX_IDLE) |-> !busy_n;
  endproperty
  a_busy_when_running: assert property (p_busy_when_running) else $error("busy low while running");

  property p_idle_not_busy;
    (state_reg == EX_IDLE && !err_sum) |-> busy_n;
  endproperty
  a_idle_not_busy: assert property (p_idle_not_busy) else $error("busy set while idle");

  property p_single_instr;
    cmd_accept |-> busy_n && state_reg == EX_IDLE;
  endproperty
  a_single_instr: assert property (p_single_instr) else $error("command taken while busy");

  property p_run_bounded;
    (state_reg == EX_RUN && run_reg == EXEC_CYCLES && !wr_cmd) |=> (state_reg == EX_RUN)[*4];
  endproperty
  a_run_bounded: assert property (p_run_bounded) else $error("execution cut short");

  property p_req_in_xfer;
    operand_xfer_request |-> (state_reg == EX_FETCH || state_reg == EX_STORE);
  endproperty
  a_req_in_xfer: assert property (p_req_in_xfer) else $error("request outside transfer");

  property p_req_drops;
    (state_reg == EX_FETCH && wr_data_done && cnt_reg == words - 3'd1 && !wr_cmd)
      |=> !operand_xfer_request ##1 state_reg == EX_RUN;
  endproperty
  a_req_drops: assert property (p_req_drops) else $error("request held after last word");

  property p_load_push;
    (state_reg == EX_RUN && run_reg == 4'h0 && op_reg == OP_LOAD && tag_reg[top_dn] && !wr_cmd)
      |=> top_reg == $past(top_dn) && !tag_reg[top_reg];
  endproperty
  a_load_push: assert property (p_load_push) else $error("load did not push");

  property p_lsw_first;
    (state_reg == EX_FETCH && wr_data_done && cnt_reg == 3'd0 && !wr_cmd)
      |=> opbuf_reg[15:0] == $past(din_reg);
  endproperty
  a_lsw_first: assert property (p_lsw_first) else $error("first word not least significant");

  property p_oe_read;
    host_data_oe |-> $past(rd_cyc);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven outside read");

  c_load: cover property (state_reg == EX_FETCH ##[1:40] state_reg == EX_RUN);
  c_store: cover property (state_reg == EX_STORE ##[1:40] state_reg == EX_IDLE);
  c_error: cover property ($fell(error_n));
  c_xchg: cover property (state_reg == EX_RUN && op_reg == OP_XCHG && run_reg == 4'h0);
endmodule

// ===== verification/ncp_host_model.sv
// Host bus model that issues coprocessor port cycles.
`timescale 1ns/10ps
module ncp_host_model (
  input  wire logic                       clk,
  input  wire logic                       busy_n,
  input  wire logic [ncp_pkg::DATA_W-1:0] host_data_out,
  output logic                            stat_one,
  output logic                            stat_zero,
  output logic                            code_ack,
  output logic                            ready_n,
  output logic                            hold,
  output logic                            ack_n,
  output logic      [ncp_pkg::ADDR_W-1:0] addr,
  output logic      [ncp_pkg::DATA_W-1:0] wdata
);
  import ncp_pkg::*;
  initial begin
    {stat_one, stat_zero, ready_n, ack_n, code_ack, hold} = 6'h3c;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // Ready stays high for two clocks after the status, then low for exactly one clock.
  task automatic cycle(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    {stat_one, stat_zero} <= wr ? BUS_WR : BUS_RD;
    addr <= a;
    wdata <= d;
    ack_n <= (a != PORT_DATA);
    repeat (2) @(posedge clk);
    ready_n <= 1'b0;
    @(posedge clk);
    q = host_data_out;
    ready_n <= 1'b1;
    @(posedge clk);
    {stat_one, stat_zero} <= 2'b11;
    ack_n <= 1'b1;
    wdata <= ~d;
    @(posedge clk);
  endtask
  // Raises hold acknowledge or the code status so that following cycles must be ignored.
  task automatic set_hold(input logic h, input logic c);
    hold <= h;
    code_ack <= c;
    @(posedge clk);
  endtask
  task automatic issue(input logic [15:0] cmd);
    logic [15:0] q;
    for (int i = 0; i < 400 && busy_n !== 1'b1; i++) @(posedge clk);
    cycle(1'b1, PORT_CMD, cmd, q);
  endtask
endmodule

// ===== verification/numeric_coprocessor_interface_test.sv
// Self-checking bench for the numeric coprocessor interface.
`timescale 1ns/10ps
module numeric_coprocessor_interface_test;
  import ncp_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  wire logic        stat1, stat0, code_ack, rdy_n, hold, ack_n, req, oe, busy_n, err_n;
  wire logic [7:0]  addr;
  wire logic [15:0] wd, rd;
  int               n_fail = 0;
  int               n_compared = 0;
  int               words [7] = '{1, 2, 4, 5, 2, 4, 5};
  logic [79:0]      one_v [7] = '{80'h1, 80'h1, 80'h1, 80'h1, 80'h3f80_0000,
                                  80'h3ff0_0000_0000_0000, 80'h3fff_8000_0000_0000_0000};
  always #12.5 clk = ~clk;
  ncp_coproc dut_u (.clk(clk), .rst(rst), .host_bus_status_one(stat1),
    .host_bus_status_zero(stat0),
    .code_or_int_ack_status(code_ack), .host_ready_n(rdy_n), .hold_acknowledge(hold),
    .host_io_addr(addr), .host_data_in(wd), .host_data_out(rd), .host_data_oe(oe),
    .operand_xfer_request(req), .operand_xfer_ack_n(ack_n), .busy_n(busy_n), .error_n(err_n));
  ncp_host_model host_u (.clk(clk), .busy_n(busy_n), .host_data_out(rd), .stat_one(stat1),
    .stat_zero(stat0), .code_ack(code_ack), .ready_n(rdy_n), .hold(hold), .ack_n(ack_n),
    .addr(addr), .wdata(wd));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy_n !== 1'b1; i++) @(posedge clk);
    check({15'h0, busy_n}, 16'h0001);
  endtask
  // Loads push and stores pop, so each pair leaves the stack as it was.
  task automatic xfer(input logic st, input logic [2:0] f, input logic [79:0] v);
    logic [15:0] q;
    host_u.issue(st ? {8'h08, 1'b0, f, 4'h1} : {9'h0, f, 4'h0});
    for (int i = 0; i < 400 && req !== 1'b1; i++) @(posedge clk);
    check({15'h0, req}, 16'h0001);
    for (int w = 0; w < words[f]; w++) begin
      host_u.cycle(!st, PORT_DATA, v[16*w +: 16], q);
      if (st) check(q, v[16*w +: 16]);
    end
    wait_idle();
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check({12'h0, busy_n, err_n, req, oe}, 16'h000c);
    $display("test_reset done");
  endtask
  task automatic test_formats();
    for (int f = 0; f < 7; f++) begin
      xfer(1'b0, 3'(f), one_v[f]);
      xfer(1'b1, 3'h0, 80'h1);
      host_u.issue(16'h0006);
      wait_idle();
      xfer(1'b1, 3'(f), one_v[f]);
    end
    $display("test_formats done");
  endtask
  task automatic test_stack();
    host_u.issue(16'h0006);
    host_u.issue(16'h0005);
    host_u.issue(16'h0102);
    host_u.issue(16'h0003);
    xfer(1'b1, 3'h0, 80'hffff);
    xfer(1'b1, 3'h0, 80'h0);
    host_u.issue(16'h0006);
    host_u.issue(16'h0003);
    host_u.issue(16'h0004);
    xfer(1'b1, 3'h0, 80'h1);
    $display("test_stack done");
  endtask
  task automatic test_hold();
    logic [15:0] q;
    host_u.set_hold(1'b1, 1'b0);
    host_u.issue(16'h0006);
    check({15'h0, busy_n}, 16'h0001);
    host_u.set_hold(1'b0, 1'b1);
    host_u.issue(16'h0006);
    check({15'h0, busy_n}, 16'h0001);
    host_u.set_hold(1'b0, 1'b0);
    host_u.issue(16'h0006);
    host_u.cycle(1'b1, PORT_CMD, 16'h0008, q);
    host_u.cycle(1'b0, PORT_CMD, 16'h0000, q);
    check(q & 16'hf080, 16'h0000);
    $display("test_hold done");
  endtask
  task automatic test_error();
    logic [15:0] q;
    host_u.cycle(1'b1, PORT_CTRL, 16'h003e, q);
    host_u.issue(16'h0003);
    for (int i = 0; i < 400 && err_n !== 1'b0; i++) @(posedge clk);
    check({14'h0, busy_n, err_n}, 16'h0000);
    host_u.cycle(1'b0, PORT_CMD, 16'h0000, q);
    check(q & 16'h8081, 16'h8081);
    host_u.cycle(1'b1, PORT_CMD, 16'h0007, q);
    wait_idle();
    check({15'h0, err_n}, 16'h0001);
    host_u.cycle(1'b1, PORT_CTRL, 16'h003f, q);
    $display("test_error done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_formats();
    test_stack();
    test_hold();
    test_error();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
